// ---- src/fspc_defines.svh ----
`ifndef FSPC_DEFINES_SVH
`define FSPC_DEFINES_SVH

// clock and timing
`define FSPC_CLK_PERIOD_NS            100
`define FSPC_GUARD_FILT_NS            500
`define FSPC_GUARD_FILT_CYC           \
  ((`FSPC_GUARD_FILT_NS + `FSPC_CLK_PERIOD_NS - 1) / `FSPC_CLK_PERIOD_NS)
`define FSPC_GUARD_ASSERT_LATENCY_NS  1000
`define FSPC_GUARD_RELEASE_LATENCY_NS 1000
`define FSPC_MAP_ERASE_TIME_US        50000
`define FSPC_MAP_ERASE_CYC            ((`FSPC_MAP_ERASE_TIME_US * 1000) / `FSPC_CLK_PERIOD_NS)

// command bytes, first byte in the top bits
`define FSPC_OP_PREFIX                24'h3D2A7F
`define FSPC_OP_ENABLE                8'hA9
`define FSPC_OP_DISABLE               8'h9A
`define FSPC_OP_MAP_ERASE             8'hCF
`define FSPC_CMD_BITS                 6'h20

// map layout and values
`define FSPC_MAP_BYTES                16
`define FSPC_MAP_ERASED               8'hFF
`define FSPC_MAP_CLEAR                8'h00
`define FSPC_MAP_FACTORY_LO           8'h00
`define FSPC_MAP_FACTORY_HI           8'hFF
`define FSPC_MAP_FACTORY_LO_LAST      7
`define FSPC_S0A_MSB                  7
`define FSPC_S0A_LSB                  6
`define FSPC_S0B_MSB                  5
`define FSPC_S0B_LSB                  4
`define FSPC_HALF_ON                  2'h3
`define FSPC_S0A_PAGES                8'h08

`endif

// ---- src/fspc_pkg.sv ----
`default_nettype none
package fspc_pkg;
  typedef enum logic [1:0] {
    FSPC_ST_IDLE  = 2'b01,
    FSPC_ST_ERASE = 2'b10
  } fspc_state_t;
  typedef logic [7:0] fspc_byte_t;
endpackage
`default_nettype wire

// ---- src/fspc_link_if.sv ----
`default_nettype none
interface fspc_link_if;
  logic [31:0] cmd_word;
  logic [5:0]  bit_count;
  modport rx   (output cmd_word, output bit_count);
  modport core (input cmd_word, input bit_count);
endinterface
`default_nettype wire

// ---- src/fspc_spi_rx.sv ----
`include "fspc_defines.svh"
`default_nettype none
// link-side shifter; word and count are held after chip select
// rises, so the core reads them once the rise is synchronised
module fspc_spi_rx (
  // link pins
  input  wire logic spi_sck,
  input  wire logic spi_cs_n,
  input  wire logic spi_si,
  // to core
  fspc_link_if.rx   link
);
  logic fresh;

  // set while deselected, so the first clock of a frame restarts the word
  always_ff @(posedge spi_sck or posedge spi_cs_n) begin
    if (spi_cs_n) begin
      fresh <= 1'b1;
    end else begin
      fresh <= 1'b0;
    end
  end

  always_ff @(posedge spi_sck) begin
    if (fresh) begin
      link.cmd_word <= {31'h00000000, spi_si};
    end else begin
      link.cmd_word <= {link.cmd_word[30:0], spi_si};
    end
  end

  // saturates one past a full command so longer frames stay invalid
  always_ff @(posedge spi_sck) begin
    if (fresh) begin
      link.bit_count <= 6'h01;
    end else if (link.bit_count <= `FSPC_CMD_BITS) begin
      link.bit_count <= link.bit_count + 6'h01;
    end
  end
endmodule
`default_nettype wire

// ---- src/fspc_top.sv ----
// Operation
// - reset (power cycle) clears the software protection enable.
// - prefix then A9h enables protection for all sectors marked in map.
// - prefix then 9Ah clears the software protection enable.
// - commands act only at chip select deassertion after exactly 32 bits.
// - guard low refuses program/erase on protected sectors and the map.
// - guard low turns protection on within the assert latency.
// - guard release ends protection only if software enable is clear.
// - disable command is ignored while guard is low.
// - guard pin has an internal pull-up, enabled except while in reset.
// - guard pin is glitch filtered in both directions.
// - map holds sixteen bytes, byte n for sector n.
// - sectors 1 to 15: FFh protected, 00h unprotected.
// - sector 0 bits 7:6 pages 0-7, bits 5:4 pages 8-255, 11 protects.
// - factory map bytes 0 to 7 are 00h.
// - prefix then CFh starts a timed map erase.
// - busy reads set for the whole map erase.
// - map erase accepted whatever the software enable, unless guard low.
// - erase leaves all bytes FFh, so every sector protected.
// - status shows protection enabled, by command or guard.
`include "fspc_defines.svh"
`default_nettype none
module fspc_top #(
  parameter int MAP_ERASE_CYC = `FSPC_MAP_ERASE_CYC
) (
  // system
  input  wire logic       clk,
  input  wire logic       rst,
  // spi link
  input  wire logic       spi_sck,
  input  wire logic       spi_cs_n,
  input  wire logic       spi_si,
  // guard pin
  input  wire logic       guard_n,
  output logic            guard_pullup_en,
  // program/erase access check
  input  wire logic       op_req,
  input  wire logic       op_is_map,
  input  wire logic [3:0] op_sector,
  input  wire logic [7:0] op_page,
  output logic            op_grant,
  output logic            op_reject,
  // status
  output logic            prot_enabled,
  output logic            busy,
  input  wire logic [3:0] map_rd_idx,
  output logic [7:0]      map_rd_data
);
  localparam int GUARD_FILT_CYC = `FSPC_GUARD_FILT_CYC;
  localparam logic [3:0] FILT_LAST = 4'(GUARD_FILT_CYC - 1);
  localparam logic [19:0] ERASE_LAST = 20'(MAP_ERASE_CYC - 1);
  localparam int GUARD_ASSERT_CYC =
    `FSPC_GUARD_ASSERT_LATENCY_NS / `FSPC_CLK_PERIOD_NS;
  localparam int GUARD_RELEASE_CYC =
    `FSPC_GUARD_RELEASE_LATENCY_NS / `FSPC_CLK_PERIOD_NS;

  fspc_link_if link ();

  fspc_spi_rx u_rx (
    .spi_sck  (spi_sck),
    .spi_cs_n (spi_cs_n),
    .spi_si   (spi_si),
    .link     (link.rx)
  );

  // chip select into clk domain
  logic cs_s1;
  logic cs_s2;
  logic cs_s3;
  always_ff @(posedge clk) begin
    if (rst) begin
      cs_s1 <= 1'b1;
      cs_s2 <= 1'b1;
      cs_s3 <= 1'b1;
    end else begin
      cs_s1 <= spi_cs_n;
      cs_s2 <= cs_s1;
      cs_s3 <= cs_s2;
    end
  end

  // link word is static while chip select is high
  logic        cs_rise;
  logic        cmd_fire;
  logic [7:0]  cmd_op;
  logic        cmd_enable;
  logic        cmd_disable;
  logic        cmd_erase;
  assign cs_rise     = cs_s2 & ~cs_s3;
  assign cmd_fire    = cs_rise && (link.bit_count == `FSPC_CMD_BITS) &&
                       (link.cmd_word[31:8] == `FSPC_OP_PREFIX);
  assign cmd_op      = link.cmd_word[7:0];
  assign cmd_enable  = cmd_fire && (cmd_op == `FSPC_OP_ENABLE);
  assign cmd_disable = cmd_fire && (cmd_op == `FSPC_OP_DISABLE);
  assign cmd_erase   = cmd_fire && (cmd_op == `FSPC_OP_MAP_ERASE);

  // guard pin sync then filter
  logic       g_s1;
  logic       g_s2;
  logic       guard_act;
  logic [3:0] filt_cnt;
  always_ff @(posedge clk) begin
    if (rst) begin
      g_s1 <= 1'b1;
      g_s2 <= 1'b1;
    end else begin
      g_s1 <= guard_n;
      g_s2 <= g_s1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      filt_cnt  <= 4'h0;
      guard_act <= 1'b0;
    end else if (~g_s2 == guard_act) begin
      filt_cnt <= 4'h0;
    end else if (filt_cnt == FILT_LAST) begin
      filt_cnt  <= 4'h0;
      guard_act <= ~g_s2;
    end else begin
      filt_cnt <= filt_cnt + 4'h1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      guard_pullup_en <= 1'b0;
    end else begin
      guard_pullup_en <= 1'b1;
    end
  end

  // software enable
  logic sw_en;
  always_ff @(posedge clk) begin
    if (rst) begin
      sw_en <= 1'b0;
    end else if (cmd_enable && !busy) begin
      sw_en <= 1'b1;
    end else if (cmd_disable && !busy && !guard_act) begin
      sw_en <= 1'b0;
    end
  end

  logic prot_on;
  assign prot_on = sw_en | guard_act;
  always_ff @(posedge clk) begin
    if (rst) begin
      prot_enabled <= 1'b0;
    end else begin
      prot_enabled <= prot_on;
    end
  end

  // map erase sequencer
  fspc_pkg::fspc_state_t state;
  logic [19:0]           erase_cnt;
  logic                  erase_done;
  assign erase_done = (state == fspc_pkg::FSPC_ST_ERASE) && (erase_cnt == ERASE_LAST);

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= fspc_pkg::FSPC_ST_IDLE;
    end else begin
      case (state)
        fspc_pkg::FSPC_ST_IDLE: begin
          if (cmd_erase && !guard_act) begin
            state <= fspc_pkg::FSPC_ST_ERASE;
          end
        end
        fspc_pkg::FSPC_ST_ERASE: begin
          if (erase_done) begin
            state <= fspc_pkg::FSPC_ST_IDLE;
          end
        end
        default: begin
          state <= fspc_pkg::FSPC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst || state != fspc_pkg::FSPC_ST_ERASE) begin
      erase_cnt <= 20'h00000;
    end else begin
      erase_cnt <= erase_cnt + 20'h00001;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      busy <= 1'b0;
    end else begin
      busy <= (state == fspc_pkg::FSPC_ST_IDLE) ? (cmd_erase && !guard_act) : !erase_done;
    end
  end

  // protection map, one byte per sector
  fspc_pkg::fspc_byte_t map [`FSPC_MAP_BYTES];
  logic [`FSPC_MAP_BYTES-1:0] map_all_ff;
  genvar gi;
  generate
    for (gi = 0; gi < `FSPC_MAP_BYTES; gi++) begin : g_map
      always_ff @(posedge clk) begin
        if (rst) begin
          map[gi] <= (gi <= `FSPC_MAP_FACTORY_LO_LAST) ?
                     `FSPC_MAP_FACTORY_LO : `FSPC_MAP_FACTORY_HI;
        end else if (erase_done) begin
          map[gi] <= `FSPC_MAP_ERASED;
        end
      end
      assign map_all_ff[gi] = (map[gi] == `FSPC_MAP_ERASED);
    end
  endgenerate

  always_ff @(posedge clk) begin
    if (rst) begin
      map_rd_data <= 8'h00;
    end else begin
      map_rd_data <= map[map_rd_idx];
    end
  end

  // sector marking
  fspc_pkg::fspc_byte_t sel_byte;
  logic                 marked;
  always_comb begin
    sel_byte = map[op_sector];
    if (op_sector == 4'h0) begin
      if (op_page < `FSPC_S0A_PAGES) begin
        marked = (sel_byte[`FSPC_S0A_MSB:`FSPC_S0A_LSB] == `FSPC_HALF_ON);
      end else begin
        marked = (sel_byte[`FSPC_S0B_MSB:`FSPC_S0B_LSB] == `FSPC_HALF_ON);
      end
    end else begin
      marked = (sel_byte == `FSPC_MAP_ERASED);
    end
  end

  logic deny;
  assign deny = busy || (op_is_map ? guard_act : (prot_on && marked));

  always_ff @(posedge clk) begin
    if (rst) begin
      op_grant  <= 1'b0;
      op_reject <= 1'b0;
    end else begin
      op_grant  <= op_req && !deny;
      op_reject <= op_req && deny;
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_RESET_CLEARS_SW: assert property ($fell(rst) |-> !sw_en && !prot_enabled)
    else $error("software enable not clear after reset");
  AST_ENABLE_CMD: assert property (cmd_enable && !busy |=> sw_en ##1 prot_enabled)
    else $error("enable command did not enable protection");
  AST_DISABLE_CMD: assert property (cmd_disable && !busy && !guard_act |=> !sw_en)
    else $error("disable command did not clear enable");
  AST_ONLY_AT_CS: assert property ($changed(sw_en) |-> $past(cmd_fire))
    else $error("software enable changed without chip select rise");
  AST_GUARD_ON: assert property ($fell(g_s2) ##1 (!g_s2)[*5]
    |-> ##[0:3] prot_enabled)
    else $error("guard did not enable protection in time");
  AST_GUARD_RELEASE: assert property ($fell(guard_act) && !sw_en |=> !prot_enabled)
    else $error("protection stayed on after guard release");
  AST_DISABLE_IGNORED: assert property (cmd_disable && guard_act && sw_en |=> sw_en)
    else $error("disable honoured while guard low");
  AST_FILTER: assert property ($changed(guard_act) |-> $past(filt_cnt) == FILT_LAST)
    else $error("guard changed before filter time");
  AST_MAP_LOCK: assert property (op_req && op_is_map && guard_act
    |=> op_reject && !op_grant)
    else $error("map access granted while guard low");
  AST_ERASE_LOCK: assert property (cmd_erase && guard_act && !busy |=> !busy)
    else $error("map erase started while guard low");
  AST_ERASE_START: assert property (cmd_erase && !guard_act && !busy |=> busy[*2])
    else $error("busy not raised for map erase");
  AST_ERASE_RESULT: assert property ($fell(busy) |-> &map_all_ff)
    else $error("map not erased at end of busy");
  AST_SECTOR_DENY: assert property (op_req && !op_is_map && prot_on && marked |=> op_reject)
    else $error("protected sector access granted");

  CVR_ENABLE: cover property (cmd_enable ##2 prot_enabled);
  CVR_ERASE_DONE: cover property ($fell(busy));
  CVR_GUARD_WITH_SW: cover property (sw_en && $rose(guard_act));
  CVR_REJECT: cover property (op_reject && !op_is_map);

  initial begin
    assert (GUARD_FILT_CYC + 4 <= GUARD_ASSERT_CYC)
      else $error("guard filter exceeds assert latency");
    assert (GUARD_FILT_CYC + 4 <= GUARD_RELEASE_CYC)
      else $error("guard filter exceeds release latency");
  end
endmodule
`default_nettype wire

// ---- dv/fspc_spi_host.sv ----
`default_nettype none
module fspc_spi_host (
  // link pins
  output logic sck,
  output logic cs_n,
  output logic si
);
  timeunit 1ns;
  timeprecision 1ns;
  // a clean deselect edge once every process is waiting
  initial begin
    sck = 1'b0;
    cs_n = 1'b0;
    si = 1'b1;
    #5;
    cs_n = 1'b1;
  end
  // mode 0, msb first, sck still outside frames
  task automatic send(input logic [31:0] word, input int hold_ns);
    #7;
    cs_n = 1'b0;
    for (int i = 31; i >= 0; i--) begin
      si = word[i];
      #32 sck = 1'b1;
      #32 sck = 1'b0;
    end
    #(hold_ns);
    cs_n = 1'b1;
    si = ~si;
    #600;
  endtask
endmodule
`default_nettype wire

// ---- dv/testbench.sv ----
`include "fspc_defines.svh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clk = 1'b0;
  logic       rst = 1'b1;
  logic       guard_lo = 1'b0;
  logic       op_req = 1'b0;
  logic       op_is_map = 1'b0;
  logic [3:0] op_sector = 4'h0;
  logic [7:0] op_page = 8'h00;
  logic [3:0] map_rd_idx = 4'h0;
  wire        spi_sck;
  wire        spi_cs_n;
  wire        spi_si;
  wire        guard_n;
  logic       guard_pullup_en;
  logic       op_grant;
  logic       op_reject;
  logic       prot_enabled;
  logic       busy;
  logic [7:0] map_rd_data;
  int         miscompares = 0;
  int         checked = 0;
  int         seed = 32'hb7d8;
  logic       expq[$];
  localparam logic [31:0] EN = {`FSPC_OP_PREFIX, `FSPC_OP_ENABLE};
  localparam logic [31:0] DIS = {`FSPC_OP_PREFIX, `FSPC_OP_DISABLE};
  localparam logic [31:0] ERA = {`FSPC_OP_PREFIX, `FSPC_OP_MAP_ERASE};
  always #50 clk = ~clk;
  // unconnected pin reads the internal pull-up
  assign guard_n = guard_lo ? 1'b0 : guard_pullup_en;
  fspc_spi_host fspc_spi_host_inst (.sck(spi_sck), .cs_n(spi_cs_n), .si(spi_si));
  fspc_top #(.MAP_ERASE_CYC(20)) fspc_top_inst (
    .clk(clk), .rst(rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_si(spi_si),
    .guard_n(guard_n), .guard_pullup_en(guard_pullup_en), .op_req(op_req),
    .op_is_map(op_is_map), .op_sector(op_sector), .op_page(op_page), .op_grant(op_grant),
    .op_reject(op_reject), .prot_enabled(prot_enabled), .busy(busy),
    .map_rd_idx(map_rd_idx), .map_rd_data(map_rd_data));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic close_out;
    if (miscompares == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic wait_st(input bit on_busy, input logic want, input int bound);
    logic v;
    v = ~want;
    for (int i = 0; i < bound && v !== want; i++) begin
      @(negedge clk);
      v = on_busy ? busy : prot_enabled;
    end
    check(on_busy ? "busy" : "prot_enabled", 8'(v), 8'(want));
    if (v !== want) close_out();
  endtask
  task automatic op(input logic m, input logic [3:0] s, input logic [7:0] p, input logic rej);
    @(posedge clk);
    op_req <= 1'b1;
    op_is_map <= m;
    op_sector <= s;
    op_page <= p;
    expq.push_back(rej);
    @(posedge clk);
    op_req <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd_all(input logic [7:0] lo, input logic [7:0] hi);
    for (int i = 0; i < 16; i++) begin
      @(posedge clk);
      map_rd_idx <= 4'(i);
      @(posedge clk);
      @(negedge clk);
      check("map_rd_data", map_rd_data, i < 8 ? lo : hi);
    end
  endtask
  task automatic guard(input logic lo, input int cyc);
    @(posedge clk);
    guard_lo <= lo;
    repeat (cyc) @(posedge clk);
  endtask
  // results are compared in the order they were asked for, mid-cycle
  always @(negedge clk) begin
    if (op_grant === 1'b1 || op_reject === 1'b1) begin
      check("op_both", 8'(op_grant & op_reject), 8'h00);
      if (expq.size() == 0) check("op_spare", 8'h01, 8'h00);
      else check("op_reject", 8'(op_reject), 8'(expq.pop_front()));
    end
  end
  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    check("pullup", 8'(guard_pullup_en), 8'h01);
    check("prot_enabled", 8'(prot_enabled), 8'h00);
    rd_all(`FSPC_MAP_FACTORY_LO, `FSPC_MAP_FACTORY_HI);
    op(1'b0, 4'h9, 8'($random(seed)), 1'b0);
    fork
      fspc_spi_host_inst.send(EN, 1500);
      #2850 check("early", 8'(prot_enabled), 8'h00);
    join
    wait_st(1'b0, 1'b1, 10);
    op(1'b0, 4'h9, 8'($random(seed)), 1'b1);
    op(1'b0, 4'h3, 8'($random(seed)), 1'b0);
    op(1'b0, 4'h0, 8'h03, 1'b0);
    fspc_spi_host_inst.send(DIS, 100);
    wait_st(1'b0, 1'b0, 10);
    guard(1'b1, 2);
    guard(1'b0, 12);
    check("glitch", 8'(prot_enabled), 8'h00);
    guard(1'b1, 0);
    wait_st(1'b0, 1'b1, 12);
    op(1'b1, 4'h0, 8'h00, 1'b1);
    fspc_spi_host_inst.send(DIS, 100);
    fspc_spi_host_inst.send(ERA, 100);
    check("prot_held", 8'(prot_enabled), 8'h01);
    check("busy_locked", 8'(busy), 8'h00);
    guard(1'b0, 0);
    wait_st(1'b0, 1'b0, 12);
    fspc_spi_host_inst.send(EN, 100);
    guard(1'b1, 10);
    fspc_spi_host_inst.send(DIS, 100);
    guard(1'b0, 15);
    check("prot_kept", 8'(prot_enabled), 8'h01);
    fspc_spi_host_inst.send(ERA, 100);
    wait_st(1'b1, 1'b1, 10);
    op(1'b0, 4'h3, 8'h00, 1'b1);
    wait_st(1'b1, 1'b0, 40);
    rd_all(`FSPC_MAP_ERASED, `FSPC_MAP_ERASED);
    op(1'b0, 4'h1 + 4'($unsigned($random(seed)) % 15), 8'h00, 1'b1);
    op(1'b0, 4'h0, 8'h07, 1'b1);
    op(1'b0, 4'h0, 8'hC8, 1'b1);
    fspc_spi_host_inst.send(DIS, 100);
    wait_st(1'b0, 1'b0, 10);
    op(1'b0, 4'h0, 8'h08, 1'b0);
    fspc_spi_host_inst.send(EN, 100);
    wait_st(1'b0, 1'b1, 10);
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(negedge clk);
    check("power_cycle", 8'(prot_enabled), 8'h00);
    op(1'b0, 4'h9, 8'h00, 1'b0);
    repeat (4) @(posedge clk);
    check("queue", 8'(expq.size()), 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
